// ---- bench/tb_top.sv ----
// Self-checking bench for the RF config register block.
// Assumes rfc_regs as the only design module, reached over AHB-Lite.
`include "rfc_cfg.svh"
`timescale 1ns/10ps
module tb_top;
   logic CLOCK, RSTN, HSEL, HWRITE, HREADYOUT, HRESP, SOFT_PWRDN;
   logic ANTENNA_DRIVE_ONE, ANTENNA_DRIVE_TWO, TX_END, FIELD_ON, RX_BIT, TIMER_TICK;
   logic DETECTOR_AMP_ENABLE, TIMER_RUNNING, IRQ, rd_pend;
   logic [11:0] HADDR;
   logic [1:0] HTRANS, TIMER_GATE_SELECT;
   logic [31:0] HWDATA, HRDATA, exp_v, seed;
   logic [31:0] exp_q[$];
   logic [7:0] N_DRIVER_OFF_CONDUCTANCE, v, nsel;
   logic [15:0] TIMER_RELOAD;
   logic [5:0] RX_GAIN_DB, P_UNMOD_CONDUCTANCE, P_MOD_CONDUCTANCE;
   logic [3:0] DETECTOR_SENSITIVITY, N_UNMOD_CONDUCTANCE, N_MOD_CONDUCTANCE;
   logic [3:0] TIMER_PRESCALE_UPPER;
   logic [5:0] gtab [8];
   int compares, miscompares, cycles, i;
   wire [31:0] obs_rx = {21'h0, DETECTOR_AMP_ENABLE, RX_GAIN_DB, DETECTOR_SENSITIVITY};
   wire [31:0] obs_drv = {12'h0, N_UNMOD_CONDUCTANCE, N_MOD_CONDUCTANCE,
      P_UNMOD_CONDUCTANCE, P_MOD_CONDUCTANCE};

   // ==========================================
   // Design under test, single slave so its ready is the bus ready
   rfc_regs rfc_regs_inst (
      .CLOCK(CLOCK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .SOFT_PWRDN(SOFT_PWRDN),
      .ANTENNA_DRIVE_ONE(ANTENNA_DRIVE_ONE), .ANTENNA_DRIVE_TWO(ANTENNA_DRIVE_TWO),
      .N_DRIVER_OFF_CONDUCTANCE(N_DRIVER_OFF_CONDUCTANCE), .TX_END(TX_END),
      .FIELD_ON(FIELD_ON), .RX_BIT(RX_BIT), .TIMER_TICK(TIMER_TICK),
      .TIMER_RELOAD(TIMER_RELOAD), .DETECTOR_AMP_ENABLE(DETECTOR_AMP_ENABLE),
      .RX_GAIN_DB(RX_GAIN_DB), .DETECTOR_SENSITIVITY(DETECTOR_SENSITIVITY),
      .N_UNMOD_CONDUCTANCE(N_UNMOD_CONDUCTANCE), .N_MOD_CONDUCTANCE(N_MOD_CONDUCTANCE),
      .P_UNMOD_CONDUCTANCE(P_UNMOD_CONDUCTANCE), .P_MOD_CONDUCTANCE(P_MOD_CONDUCTANCE),
      .TIMER_GATE_SELECT(TIMER_GATE_SELECT), .TIMER_PRESCALE_UPPER(TIMER_PRESCALE_UPPER),
      .TIMER_RUNNING(TIMER_RUNNING), .IRQ(IRQ)
   );

   // ==========================================
   // Clock of 50 ns period
   initial begin
      CLOCK = 1'b0;
      forever #25 CLOCK = ~CLOCK;
   end

   // ==========================================
   // Comparison, verdict and hang guard
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge CLOCK) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         close_out();
      end
   end

   // Read data is taken at the edge where ready returns high
   always @(posedge CLOCK) begin
      if (rd_pend && HREADYOUT === 1'b1) begin
         rd_pend = 1'b0;
         exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hDEAD_BEEF;
         chk(HRDATA, exp_v);
         chk({31'h0, HRESP}, 32'h0);
      end
      if (HSEL && HTRANS[1] && !HWRITE && HREADYOUT === 1'b1) begin
         rd_pend = 1'b1;
      end
   end

   // ==========================================
   // Bus and event drivers, entered just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] dat);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= wr;
      HADDR <= {2'h0, idx, 2'h0};
      @(posedge CLOCK);
      while (HREADYOUT !== 1'b1) @(posedge CLOCK);
      HTRANS <= 2'h0;
      HSEL <= 1'b0;
      HWDATA <= {24'h0, dat};
      @(posedge CLOCK);
      while (HREADYOUT !== 1'b1) @(posedge CLOCK);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      exp_q.push_back({24'h0, exp});
      bus(1'b0, idx, 8'h00);
   endtask

   // Pulses of one cycle: 0 end of transmission, 1 received bit, 2 timer tick
   task automatic ev(input int k, input int n);
      repeat (n) begin
         TX_END <= (k == 0);
         RX_BIT <= (k == 1);
         TIMER_TICK <= (k == 2);
         @(posedge CLOCK);
         TX_END <= 1'b0;
         RX_BIT <= 1'b0;
         TIMER_TICK <= 1'b0;
         @(posedge CLOCK);
      end
      repeat (2) @(posedge CLOCK);
   endtask

   task automatic run(input logic e);
      chk({31'h0, TIMER_RUNNING}, {31'h0, e});
   endtask

   // ==========================================
   // Main sequence
   initial begin
      gtab = '{`RFC_GAIN_18, `RFC_GAIN_23, `RFC_GAIN_18, `RFC_GAIN_23,
         `RFC_GAIN_33, `RFC_GAIN_38, `RFC_GAIN_43, `RFC_GAIN_48};
      seed = 32'h68AC;
      {compares, miscompares, cycles} = '0;
      {RSTN, HSEL, HWRITE, SOFT_PWRDN, ANTENNA_DRIVE_ONE, ANTENNA_DRIVE_TWO} = '0;
      {TX_END, FIELD_ON, RX_BIT, TIMER_TICK, rd_pend} = '0;
      {HADDR, HTRANS, HWDATA} = '0;
      TIMER_RELOAD = 16'h0003;
      N_DRIVER_OFF_CONDUCTANCE = $random(seed);
      repeat (16) @(posedge CLOCK);
      RSTN <= 1'b1;
      @(posedge CLOCK);
      rd(`RFC_IDX_RX_CFG, `RFC_RST_RX_CFG);
      rd(`RFC_IDX_N_ON, `RFC_RST_N_ON);
      rd(`RFC_IDX_P_UNMOD, {2'h0, `RFC_RST_P_UNMOD});
      rd(`RFC_IDX_P_MOD, {2'h0, `RFC_RST_P_MOD});
      rd(`RFC_IDX_TMODE, `RFC_RST_TMODE);
      rd(8'h40, 8'h00);
      chk(obs_rx, {21'h0, 1'b0, `RFC_GAIN_33, 4'h8});
      // Every gain code, amplifier enable toggled
      for (i = 0; i < 8; i++) begin
         v = $random(seed);
         v[7:4] = {i[0], i[2:0]};
         bus(1'b1, `RFC_IDX_RX_CFG, v);
         repeat (2) @(posedge CLOCK);
         chk(obs_rx, {21'h0, v[7], gtab[i], v[3:0]});
         rd(`RFC_IDX_RX_CFG, v);
      end
      // Conductance bytes, reserved bits dropped
      v = $random(seed);
      bus(1'b1, `RFC_IDX_N_ON, v);
      rd(`RFC_IDX_N_ON, v);
      bus(1'b1, `RFC_IDX_P_UNMOD, 8'hFF);
      rd(`RFC_IDX_P_UNMOD, 8'h3F);
      bus(1'b1, `RFC_IDX_P_MOD, 8'hC5);
      rd(`RFC_IDX_P_MOD, 8'h05);
      // Driver on or off selection, power-down forcing
      for (i = 0; i < 8; i++) begin
         {SOFT_PWRDN, ANTENNA_DRIVE_TWO, ANTENNA_DRIVE_ONE} <= i[2:0];
         repeat (3) @(posedge CLOCK);
         nsel = (i[1:0] != 2'h0) ? v : N_DRIVER_OFF_CONDUCTANCE;
         chk(obs_drv, {12'h0, nsel[7:4] | {i[2], 3'h0}, nsel[3:0] | {i[2], 3'h0},
            6'h3F, 6'h05 | {i[2], 5'h0}});
      end
      bus(1'b1, `RFC_IDX_AUX, 8'h04);
      repeat (2) @(posedge CLOCK);
      chk({26'h0, P_MOD_CONDUCTANCE}, 32'h0);
      // Timer mode fields
      bus(1'b1, `RFC_IDX_TMODE, 8'h6B);
      repeat (2) @(posedge CLOCK);
      chk({26'h0, TIMER_GATE_SELECT, TIMER_PRESCALE_UPPER}, 32'h3B);
      // Automatic start, stop after five bits then four
      bus(1'b1, `RFC_IDX_TMODE, 8'h80);
      bus(1'b1, `RFC_IDX_AUX, 8'h08);
      ev(0, 1);
      run(1'b1);
      ev(1, 4);
      run(1'b1);
      ev(1, 1);
      run(1'b0);
      bus(1'b1, `RFC_IDX_AUX, 8'h00);
      ev(0, 1);
      ev(1, 3);
      run(1'b1);
      ev(1, 1);
      run(1'b0);
      // Multi-frame receive: only the halt request stops
      bus(1'b1, `RFC_IDX_AUX, 8'h02);
      ev(0, 1);
      ev(1, 6);
      run(1'b1);
      bus(1'b1, `RFC_IDX_CTRL, 8'h80);
      repeat (2) @(posedge CLOCK);
      run(1'b0);
      // Start on field turning on
      bus(1'b1, `RFC_IDX_AUX, 8'h01);
      FIELD_ON <= 1'b1;
      repeat (3) @(posedge CLOCK);
      run(1'b1);
      bus(1'b1, `RFC_IDX_CTRL, 8'h80);
      FIELD_ON <= 1'b0;
      // Protocol ignored without automatic start; expiry raises the flag
      bus(1'b1, `RFC_IDX_TMODE, 8'h00);
      bus(1'b1, `RFC_IDX_IRQ_ST, 8'h07);
      ev(0, 1);
      run(1'b0);
      bus(1'b1, `RFC_IDX_CTRL, 8'h40);
      ev(1, 6);
      run(1'b1);
      ev(2, 5);
      rd(`RFC_IDX_IRQ_ST, 8'h01);
      chk({31'h0, IRQ}, 32'h0);
      bus(1'b1, `RFC_IDX_IRQ_MASK, 8'h01);
      repeat (3) @(posedge CLOCK);
      chk({31'h0, IRQ}, 32'h1);
      bus(1'b1, `RFC_IDX_IRQ_ST, 8'h01);
      repeat (3) @(posedge CLOCK);
      chk({31'h0, IRQ}, 32'h0);
      rd(`RFC_IDX_IRQ_ST, 8'h00);
      repeat (4) @(posedge CLOCK);
      close_out();
   end
endmodule

// ---- core/rfc_regs.sv ----
// Receiver gain, antenna driver conductance and timer mode registers on AHB-Lite.
// Assumes one clock, synchronous inputs and a single AHB-Lite master.
// Operation
// - Receiver config byte, 0x26, reset 0x48.
// - Gain codes map to 18 through 48 dB.
// - Amp enable bit switches level detector amplifier.
// - N-driver on conductance byte, 0x27, reset 0x88.
// - On values only while an antenna drives.
// - Soft power-down forces conductance top bits high, except P modulation under forced full-depth ASK.
// - P unmodulated conductance, 0x28, reset 0x20.
// - P modulation conductance, 0x29, reset 0x20.
// - Forced full-depth ASK ignores P modulation value.
// - Timer mode byte, 0x2A, reset 0x00.
// - Auto start on transmit end, field on.
// - Short modes stop timer after fifth bit.
// - Other modes stop timer after fourth bit.
// - Multi-frame receive: only halt request stops.
// - Auto start clear: protocol leaves timer alone.
// - No restart: count to zero, flag expiry.
//
// Design decision made here: the AHB-Lite register port.
`include "rfc_cfg.svh"
`timescale 1ns/10ps
module rfc_regs (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic HSEL,
   input wire logic [11:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   input wire logic SOFT_PWRDN,
   input wire logic ANTENNA_DRIVE_ONE,
   input wire logic ANTENNA_DRIVE_TWO,
   input wire logic [7:0] N_DRIVER_OFF_CONDUCTANCE,
   input wire logic TX_END,
   input wire logic FIELD_ON,
   input wire logic RX_BIT,
   input wire logic TIMER_TICK,
   input wire logic [15:0] TIMER_RELOAD,
   output logic DETECTOR_AMP_ENABLE,
   output logic [5:0] RX_GAIN_DB,
   output logic [3:0] DETECTOR_SENSITIVITY,
   output logic [3:0] N_UNMOD_CONDUCTANCE,
   output logic [3:0] N_MOD_CONDUCTANCE,
   output logic [5:0] P_UNMOD_CONDUCTANCE,
   output logic [5:0] P_MOD_CONDUCTANCE,
   output logic [1:0] TIMER_GATE_SELECT,
   output logic [3:0] TIMER_PRESCALE_UPPER,
   output logic TIMER_RUNNING,
   output logic IRQ
);
   rfc_pkg::rfc_state_t q, d;
   logic tmr_start;
   logic tmr_stop;
   logic tmr_running;
   logic [15:0] tmr_count;
   logic tmr_expired;
   logic auto_start;
   logic auto_stop;
   logic field_rise;
   logic [2:0] need_bits;
   logic drivers_on;
   logic [7:0] n_sel;

   // ==========================================
   // Gain code to dB
   function automatic logic [5:0] gain_db(input logic [2:0] code);
      unique case (code)
         3'h0, 3'h2: gain_db = `RFC_GAIN_18;
         3'h1, 3'h3: gain_db = `RFC_GAIN_23;
         3'h4: gain_db = `RFC_GAIN_33;
         3'h5: gain_db = `RFC_GAIN_38;
         3'h6: gain_db = `RFC_GAIN_43;
         3'h7: gain_db = `RFC_GAIN_48;
      endcase
   endfunction

   // ==========================================
   // Protocol events steering the timer
   always_comb begin
      field_rise = FIELD_ON && !q.field;
      auto_start = q.tmode[`RFC_TMODE_AUTO] &&
         (TX_END || (q.aux[`RFC_AUX_INIT] && field_rise));
      need_bits = q.aux[`RFC_AUX_SHORT] ? `RFC_RX_BITS_SHORT : `RFC_RX_BITS_LONG;
      auto_stop = q.armed && RX_BIT && q.tmode[`RFC_TMODE_AUTO] &&
         !q.aux[`RFC_AUX_MULTI] && (q.bit_cnt + 3'h1 == need_bits);
      tmr_start = auto_start || q.go;
      tmr_stop = auto_stop || q.halt;
      drivers_on = ANTENNA_DRIVE_ONE || ANTENNA_DRIVE_TWO;
      n_sel = drivers_on ? q.n_on : N_DRIVER_OFF_CONDUCTANCE;
   end

   // ==========================================
   // Next state of bank, bus slave and outputs
   always_comb begin
      d = q;
      d.halt = 1'b0;
      d.go = 1'b0;
      d.field = FIELD_ON;
      // Write data phase
      if (q.ap_valid && q.ap_write && q.hready) begin
         unique case (q.ap_idx)
            `RFC_IDX_RX_CFG: d.rf_cfg = HWDATA[7:0];
            `RFC_IDX_N_ON: d.n_on = HWDATA[7:0];
            `RFC_IDX_P_UNMOD: d.p_unmod = HWDATA[5:0];
            `RFC_IDX_P_MOD: d.p_mod = HWDATA[5:0];
            `RFC_IDX_TMODE: d.tmode = HWDATA[7:0];
            `RFC_IDX_CTRL: begin
               d.halt = HWDATA[`RFC_CTRL_HALT];
               d.go = HWDATA[`RFC_CTRL_GO];
            end
            `RFC_IDX_AUX: d.aux = HWDATA[3:0];
            `RFC_IDX_IRQ_MASK: d.irq_mask = HWDATA[2:0];
            default: d.aux = q.aux;
         endcase
      end
      // Sticky events, set wins over write-one-to-clear
      if (q.ap_valid && q.ap_write && q.hready && q.ap_idx == `RFC_IDX_IRQ_ST) begin
         d.irq_st = q.irq_st & ~HWDATA[2:0];
      end
      d.irq_st[`RFC_IRQ_EXPIRED] = d.irq_st[`RFC_IRQ_EXPIRED] | tmr_expired;
      d.irq_st[`RFC_IRQ_ASTART] = d.irq_st[`RFC_IRQ_ASTART] | auto_start;
      d.irq_st[`RFC_IRQ_ASTOP] = d.irq_st[`RFC_IRQ_ASTOP] | auto_stop;
      // Read data phase, one wait state
      if (q.rd_pend) begin
         d.rd_pend = 1'b0;
         d.hready = 1'b1;
         d.hrdata = 32'h0000_0000;
         unique case (q.ap_idx)
            `RFC_IDX_RX_CFG: d.hrdata[7:0] = q.rf_cfg;
            `RFC_IDX_N_ON: d.hrdata[7:0] = q.n_on;
            `RFC_IDX_P_UNMOD: d.hrdata[5:0] = q.p_unmod;
            `RFC_IDX_P_MOD: d.hrdata[5:0] = q.p_mod;
            `RFC_IDX_TMODE: d.hrdata[7:0] = q.tmode;
            `RFC_IDX_AUX: d.hrdata[3:0] = q.aux;
            `RFC_IDX_IRQ_ST: d.hrdata[2:0] = q.irq_st;
            `RFC_IDX_IRQ_MASK: d.hrdata[2:0] = q.irq_mask;
            `RFC_IDX_TSTAT: d.hrdata[0] = tmr_running;
            `RFC_IDX_TCNT_LO: d.hrdata[7:0] = tmr_count[7:0];
            `RFC_IDX_TCNT_HI: d.hrdata[7:0] = tmr_count[15:8];
            default: d.hrdata = 32'h0000_0000;
         endcase
      end
      // Address phase
      if (HREADY) begin
         d.ap_valid = HSEL && HTRANS[1];
         d.ap_write = HWRITE;
         d.ap_idx = HADDR[9:2];
         if (HSEL && HTRANS[1] && !HWRITE) begin
            d.rd_pend = 1'b1;
            d.hready = 1'b0;
         end
      end
      // Received-bit counter for the automatic stop
      if (tmr_start) begin
         d.armed = !q.aux[`RFC_AUX_MULTI];
         d.bit_cnt = 3'h0;
      end else if (auto_stop || q.halt) begin
         d.armed = 1'b0;
      end else if (q.armed && RX_BIT) begin
         d.bit_cnt = q.bit_cnt + 3'h1;
      end
      // Driver outputs
      d.amp_o = q.rf_cfg[`RFC_RX_AMP_BIT];
      d.gain_o = gain_db(q.rf_cfg[6:4]);
      d.n_unmod_o = n_sel[7:4];
      d.n_mod_o = n_sel[3:0];
      d.p_unmod_o = q.p_unmod;
      d.p_mod_o = q.aux[`RFC_AUX_FORCE] ? 6'h00 : q.p_mod;
      if (SOFT_PWRDN) begin
         d.n_unmod_o[3] = 1'b1;
         d.n_mod_o[3] = 1'b1;
         d.p_unmod_o[5] = 1'b1;
         if (!q.aux[`RFC_AUX_FORCE]) begin
            d.p_mod_o[5] = 1'b1;
         end
      end
      d.irq_o = |(q.irq_st & q.irq_mask);
   end

   // ==========================================
   // State register with documented resets
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         q <= '0;
         q.rf_cfg <= `RFC_RST_RX_CFG;
         q.n_on <= `RFC_RST_N_ON;
         q.p_unmod <= `RFC_RST_P_UNMOD;
         q.p_mod <= `RFC_RST_P_MOD;
         q.tmode <= `RFC_RST_TMODE;
         q.hready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ==========================================
   // Timer
   rfc_timer u_timer (
      .clock(CLOCK),
      .rst_n(RSTN),
      .start(tmr_start),
      .stop(tmr_stop),
      .tick(TIMER_TICK),
      .reload(TIMER_RELOAD),
      .repeat_en(q.tmode[`RFC_TMODE_RESTART]),
      .running(tmr_running),
      .count(tmr_count),
      .expired(tmr_expired)
   );

   // Outputs straight from flip-flops
   assign HREADYOUT = q.hready;
   assign HRDATA = q.hrdata;
   assign HRESP = 1'b0;
   assign DETECTOR_AMP_ENABLE = q.amp_o;
   assign RX_GAIN_DB = q.gain_o;
   assign DETECTOR_SENSITIVITY = q.rf_cfg[3:0];
   assign N_UNMOD_CONDUCTANCE = q.n_unmod_o;
   assign N_MOD_CONDUCTANCE = q.n_mod_o;
   assign P_UNMOD_CONDUCTANCE = q.p_unmod_o;
   assign P_MOD_CONDUCTANCE = q.p_mod_o;
   assign TIMER_GATE_SELECT = q.tmode[6:5];
   assign TIMER_PRESCALE_UPPER = q.tmode[3:0];
   assign TIMER_RUNNING = tmr_running;
   assign IRQ = q.irq_o;

   // ==========================================
   // Checks
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RSTN);

   rx_cfg_write_a: assert property (
      q.ap_valid && q.ap_write && q.hready && q.ap_idx == `RFC_IDX_RX_CFG
      |=> q.rf_cfg == $past(HWDATA[7:0]))
      else $error("receiver config write lost");
   gain_map_a: assert property (
      q.rf_cfg[6:4] == 3'h2 |=> RX_GAIN_DB == 6'h12)
      else $error("gain code 2 is not 18 dB");
   amp_enable_a: assert property (
      q.rf_cfg[7] |=> DETECTOR_AMP_ENABLE)
      else $error("detector amplifier not enabled");
   off_select_a: assert property (
      !ANTENNA_DRIVE_ONE && !ANTENNA_DRIVE_TWO && !SOFT_PWRDN
      |=> N_UNMOD_CONDUCTANCE == $past(N_DRIVER_OFF_CONDUCTANCE[7:4]))
      else $error("off-state conductance not applied");
   pwrdn_force_a: assert property (
      SOFT_PWRDN |=> N_UNMOD_CONDUCTANCE[3] && N_MOD_CONDUCTANCE[3] && P_UNMOD_CONDUCTANCE[5])
      else $error("soft power-down did not force top bits");
   p_reserved_a: assert property (
      q.rd_pend && q.ap_idx == `RFC_IDX_P_UNMOD |=> HREADYOUT && HRDATA[31:6] == 26'h0)
      else $error("reserved P bits read nonzero");
   full_ask_a: assert property (
      q.aux[`RFC_AUX_FORCE] |=> P_MOD_CONDUCTANCE == 6'h00)
      else $error("P modulation value used under full-depth ASK");
   auto_start_a: assert property (
      q.tmode[7] && TX_END && !q.halt |=> TIMER_RUNNING)
      else $error("timer not started at transmit end");
   multi_nostop_a: assert property (
      q.aux[`RFC_AUX_MULTI] && !q.halt |-> !tmr_stop)
      else $error("timer stopped on bits in multi-frame receive");
   manual_only_a: assert property (
      !q.tmode[7] && !q.go && !q.halt |-> !tmr_start && !tmr_stop)
      else $error("protocol touched timer with auto start clear");
   short_stop_a: assert property (
      auto_stop && q.aux[`RFC_AUX_SHORT] |-> q.bit_cnt == 3'h4)
      else $error("short mode stop not at fifth bit");
   expiry_flag_a: assert property (
      tmr_expired |=> q.irq_st[`RFC_IRQ_EXPIRED])
      else $error("expiry flag not set");
endmodule

// ---- core/rfc_timer.sv ----
// Down-counting protocol timer of the RF config block.
// Assumes start and stop pulses from the register bank and a tick per timer period.
`timescale 1ns/10ps
module rfc_timer (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic start,
   input wire logic stop,
   input wire logic tick,
   input wire logic [15:0] reload,
   input wire logic repeat_en,
   output logic running,
   output logic [15:0] count,
   output logic expired
);
   rfc_pkg::rfc_tmr_state_t q, d;

   // ==========================================
   // Next state: stop beats start, start beats counting
   always_comb begin
      d = q;
      d.expired = 1'b0;
      if (stop) begin
         d.running = 1'b0;
      end else if (start) begin
         d.running = 1'b1;
         d.count = reload;
      end else if (q.running && tick) begin
         if (q.count == 16'h0000) begin
            if (repeat_en) begin
               d.count = reload;
            end else begin
               d.running = 1'b0;
               d.expired = 1'b1;
            end
         end else begin
            d.count = q.count - 16'h0001;
         end
      end
   end

   // State register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign running = q.running;
   assign count = q.count;
   assign expired = q.expired;

   // ==========================================
   // Checks
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   expire_at_zero_a: assert property (
      q.running && tick && q.count == 16'h0000 && !repeat_en && !start && !stop
      |=> q.expired && !q.running)
      else $error("timer did not expire at zero");
   expire_cause_a: assert property (
      q.expired |-> $past(q.running) && $past(q.count) == 16'h0000)
      else $error("timer expired without reaching zero");
endmodule

// ---- inc/rfc_cfg.svh ----
// Register map, reset values, field positions and counts of the RF config block.
// Assumes an AHB-Lite word bus; each register index sits at byte address index * 4.
`ifndef RFC_CFG_SVH
`define RFC_CFG_SVH

// ==========================================
// Register indices
`define RFC_IDX_RX_CFG 8'h26
`define RFC_IDX_N_ON 8'h27
`define RFC_IDX_P_UNMOD 8'h28
`define RFC_IDX_P_MOD 8'h29
`define RFC_IDX_TMODE 8'h2A
`define RFC_IDX_CTRL 8'h0C
`define RFC_IDX_AUX 8'h30
`define RFC_IDX_IRQ_ST 8'h31
`define RFC_IDX_IRQ_MASK 8'h32
`define RFC_IDX_TSTAT 8'h33
`define RFC_IDX_TCNT_LO 8'h34
`define RFC_IDX_TCNT_HI 8'h35

// ==========================================
// Reset values
`define RFC_RST_RX_CFG 8'h48
`define RFC_RST_N_ON 8'h88
`define RFC_RST_P_UNMOD 6'h20
`define RFC_RST_P_MOD 6'h20
`define RFC_RST_TMODE 8'h00

// ==========================================
// Field positions
`define RFC_RX_AMP_BIT 7
`define RFC_TMODE_AUTO 7
`define RFC_TMODE_RESTART 4
`define RFC_CTRL_HALT 7
`define RFC_CTRL_GO 6
`define RFC_AUX_INIT 0
`define RFC_AUX_MULTI 1
`define RFC_AUX_FORCE 2
`define RFC_AUX_SHORT 3
`define RFC_IRQ_EXPIRED 0
`define RFC_IRQ_ASTART 1
`define RFC_IRQ_ASTOP 2

// ==========================================
// Receiver gain in dB
`define RFC_GAIN_18 6'h12
`define RFC_GAIN_23 6'h17
`define RFC_GAIN_33 6'h21
`define RFC_GAIN_38 6'h26
`define RFC_GAIN_43 6'h2B
`define RFC_GAIN_48 6'h30

// ==========================================
// Received bits before an automatic stop
`define RFC_RX_BITS_SHORT 3'h5
`define RFC_RX_BITS_LONG 3'h4

`endif

// ---- inc/rfc_pkg.sv ----
// Types of the RF config block: state records of the register bank and the timer.
// Assumes rfc_cfg.svh for all numbers.
package rfc_pkg;

   // ==========================================
   // Register bank state
   typedef struct packed {
      logic [7:0] rf_cfg;
      logic [7:0] n_on;
      logic [5:0] p_unmod;
      logic [5:0] p_mod;
      logic [7:0] tmode;
      logic [3:0] aux;
      logic [2:0] irq_st;
      logic [2:0] irq_mask;
      logic ap_valid;
      logic ap_write;
      logic [7:0] ap_idx;
      logic rd_pend;
      logic hready;
      logic [31:0] hrdata;
      logic halt;
      logic go;
      logic field;
      logic armed;
      logic [2:0] bit_cnt;
      logic [3:0] n_unmod_o;
      logic [3:0] n_mod_o;
      logic [5:0] p_unmod_o;
      logic [5:0] p_mod_o;
      logic [5:0] gain_o;
      logic amp_o;
      logic irq_o;
   } rfc_state_t;

   // ==========================================
   // Timer state
   typedef struct packed {
      logic running;
      logic [15:0] count;
      logic expired;
   } rfc_tmr_state_t;

endpackage
